// File: testbench/hpa_mpu_model.sv
/*
 Controller microprocessor model: word access, event post, flag clear.
 Assumes a combinational grant and inputs changed at the falling edge.
*/
`timescale 1ns/1ps
module hpa_mpu_model
    import hpa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic mpu_ack,
    input wire logic [HPA_DATA_W-1:0] mpu_rdata,
    output logic mpu_req,
    output logic mpu_we,
    output logic [HPA_ADDR_W-1:0] mpu_addr,
    output logic [HPA_DATA_W-1:0] mpu_wdata,
    output logic mpu_event_post,
    output logic [HPA_EVT_FIELD_W-1:0] mpu_event_field,
    output logic [HPA_EVT_W-1:0] mpu_evt_clear
);
    // ************************************************************
    // Bus tasks
    // ************************************************************
    initial begin
        mpu_req = 1'b0;
        mpu_we = 1'b0;
        mpu_addr = 4'h0;
        mpu_wdata = 16'h0000;
        mpu_event_post = 1'b0;
        mpu_event_field = 5'h00;
        mpu_evt_clear = 4'h0;
    end
    // Request held until granted or for at most 20 stalled cycles; released data is inverted so stale values never match
    task automatic xfer(input logic we, input logic [HPA_ADDR_W-1:0] a,
            input logic [HPA_DATA_W-1:0] d, output logic [HPA_DATA_W-1:0] q);
        int n;
        n = 0;
        @(negedge clk_sys);
        mpu_req = 1'b1;
        mpu_we = we;
        mpu_addr = a;
        mpu_wdata = d;
        #1;
        while (!mpu_ack && n < 20) begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        @(negedge clk_sys);
        q = mpu_rdata;
        mpu_req = 1'b0;
        mpu_wdata = ~mpu_wdata;
    endtask
    task automatic post(input logic [HPA_EVT_FIELD_W-1:0] f);
        @(negedge clk_sys);
        mpu_event_field = f;
        mpu_event_post = 1'b1;
        @(negedge clk_sys);
        mpu_event_post = 1'b0;
    endtask
    task automatic clr(input logic [HPA_EVT_W-1:0] m);
        @(negedge clk_sys);
        mpu_evt_clear = m;
        @(negedge clk_sys);
        mpu_evt_clear = 4'h0;
    endtask
endmodule

// File: testbench/hpa_sva.sv
/*
 Port checker for the host port adapter, bound to its top module.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module hpa_sva
    import hpa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [HPA_ADDR_W-1:0] host_addr,
    input wire logic [HPA_DATA_W-1:0] host_wdata,
    input wire logic host_ack,
    input wire logic [HPA_DATA_W-1:0] host_rdata,
    input wire logic host_init,
    input wire logic host_irq,
    input wire logic host_irq_ack,
    input wire logic mpu_req,
    input wire logic mpu_ack,
    input wire logic [HPA_EVT_W-1:0] mpu_evt_flags,
    input wire logic mpu_irq
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_one_grant;
        !(host_ack && mpu_ack);
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("both sides granted");
    property p_ack_req;
        host_ack |-> host_req;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("grant without request");
    property p_host_served;
        host_req && !host_ack |=> !host_req || host_ack;
    endproperty
    a_host_served: assert property (p_host_served) else $error("host stalled twice");
    property p_mpu_served;
        mpu_req && !mpu_ack |=> !mpu_req || mpu_ack;
    endproperty
    a_mpu_served: assert property (p_mpu_served) else $error("mpu stalled twice");
    property p_irq_hold;
        host_irq && !host_irq_ack && !host_init |=> host_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("host irq dropped");
    property p_init_evt;
        $rose(host_init) |-> ##[1:2] (mpu_evt_flags[HPA_EVT_SR] && mpu_irq);
    endproperty
    a_init_evt: assert property (p_init_evt) else $error("init event missing");
    property p_init_irq;
        $rose(host_init) |-> ##2 !host_irq;
    endproperty
    a_init_irq: assert property (p_init_irq) else $error("init left host irq");
    property p_mpu_irq;
        mpu_irq == (|mpu_evt_flags);
    endproperty
    a_mpu_irq: assert property (p_mpu_irq) else $error("mpu irq not flag or");
    property p_go_evt;
        host_ack && host_we && host_addr == HPA_ADDR_CS1 && host_wdata[HPA_CS1_GO_BIT]
            |=> mpu_evt_flags[HPA_EVT_GO];
    endproperty
    a_go_evt: assert property (p_go_evt) else $error("go event missing");
    property p_rdata_hold;
        !host_ack |=> $stable(host_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
bind hpa_host_port_adapter hpa_sva u_hpa_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .host_req(host_req), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_ack(host_ack), .host_rdata(host_rdata), .host_init(host_init),
    .host_irq(host_irq), .host_irq_ack(host_irq_ack), .mpu_req(mpu_req),
    .mpu_ack(mpu_ack), .mpu_evt_flags(mpu_evt_flags), .mpu_irq(mpu_irq));

// File: testbench/testbench.sv
/*
 Self-checking bench for the host port adapter with a microprocessor model.
 Assumes the package address map and a 200 MHz clock.
*/
`timescale 1ns/1ps
module testbench
    import hpa_pkg::*;
;
    // ************************************************************
    // Harness
    // ************************************************************
    logic clk_sys, sys_rst, host_req, host_we, host_ack, host_init, host_irq, host_irq_ack;
    logic host_irq_is_event, mpu_req, mpu_we, mpu_ack, mpu_event_post, mpu_irq;
    logic [3:0] host_addr, mpu_addr, mpu_evt_clear, mpu_evt_flags;
    logic [15:0] host_wdata, host_rdata, mpu_wdata, mpu_rdata;
    logic [4:0] host_event_field, mpu_event_field;
    int n_fail = 0;
    int cmp_count = 0;
    hpa_host_port_adapter u_hpa_host_port_adapter (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .host_req(host_req), .host_we(host_we), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_ack(host_ack), .host_rdata(host_rdata),
        .host_init(host_init), .host_irq(host_irq), .host_irq_ack(host_irq_ack),
        .host_irq_is_event(host_irq_is_event), .host_event_field(host_event_field),
        .mpu_req(mpu_req), .mpu_we(mpu_we), .mpu_addr(mpu_addr), .mpu_wdata(mpu_wdata),
        .mpu_ack(mpu_ack), .mpu_rdata(mpu_rdata), .mpu_event_post(mpu_event_post),
        .mpu_event_field(mpu_event_field), .mpu_evt_clear(mpu_evt_clear),
        .mpu_evt_flags(mpu_evt_flags), .mpu_irq(mpu_irq));
    hpa_mpu_model u_hpa_mpu_model (.clk_sys(clk_sys), .mpu_ack(mpu_ack),
        .mpu_rdata(mpu_rdata), .mpu_req(mpu_req), .mpu_we(mpu_we), .mpu_addr(mpu_addr),
        .mpu_wdata(mpu_wdata), .mpu_event_post(mpu_event_post),
        .mpu_event_field(mpu_event_field), .mpu_evt_clear(mpu_evt_clear));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic summarize();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hx(input logic we, input logic [3:0] a, input logic [15:0] d,
            output logic [15:0] q);
        int n;
        n = 0;
        @(negedge clk_sys);
        host_req = 1'b1;
        host_we = we;
        host_addr = a;
        host_wdata = d;
        #1;
        while (!host_ack && n < 20) begin
            @(negedge clk_sys);
            #1;
            n++;
        end
        @(negedge clk_sys);
        q = host_rdata;
        host_req = 1'b0;
        host_wdata = ~host_wdata;
    endtask
    task automatic iack();
        @(negedge clk_sys);
        host_irq_ack = 1'b1;
        @(negedge clk_sys);
        host_irq_ack = 1'b0;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_cmd();
        logic [15:0] q;
        hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q, 16'h0080);
        chk({10'h000, host_irq, mpu_irq, mpu_evt_flags}, 16'h0000);
        hx(1'b1, HPA_ADDR_CS1, 16'h0057, q);
        chk({11'h000, mpu_irq, mpu_evt_flags}, 16'h0011);
        hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q, 16'h0057);
        u_hpa_mpu_model.xfer(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q, 16'h0057);
        u_hpa_mpu_model.clr(4'hF);
        u_hpa_mpu_model.xfer(1'b1, HPA_ADDR_DS, 16'h1234, q);
        chk({14'h0000, host_irq, host_irq_is_event}, 16'h0002);
        hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q, 16'h00D6);
        iack();
        chk({15'h0000, host_irq}, 16'h0000);
    endtask
    task automatic t_units();
        logic [15:0] q;
        logic [15:0] r;
        hx(1'b1, HPA_ADDR_CS2, 16'h0001, q);
        hx(1'b1, HPA_ADDR_CS1, 16'h0045, q);
        hx(1'b1, HPA_ADDR_CS2, 16'h0003, q);
        hx(1'b1, HPA_ADDR_CS1, 16'h0045, q);
        u_hpa_mpu_model.xfer(1'b1, HPA_ADDR_DS, 16'h3333, q);
        iack();
        hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q, 16'h00C4);
        hx(1'b1, HPA_ADDR_CS2, 16'h0001, q);
        hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q, 16'h00C5);
        hx(1'b0, HPA_ADDR_DS, 16'h0000, q);
        chk(q, 16'h0000);
        u_hpa_mpu_model.xfer(1'b1, HPA_ADDR_DS, 16'h1111, q);
        iack();
        u_hpa_mpu_model.clr(4'hF);
        // Same-edge requests from both sides; the host read after each tie
        // makes the host the last winner, so the second tie goes to the processor
        repeat (2) begin
            fork
                hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
                u_hpa_mpu_model.xfer(1'b1, HPA_ADDR_PAR_FIRST, 16'h0ABC, r);
            join
            chk(q, 16'h00C4);
            hx(1'b0, HPA_ADDR_PAR_FIRST, 16'h0000, q);
            chk(q, 16'h0ABC);
        end
    endtask
    task automatic t_event();
        logic [15:0] q;
        u_hpa_mpu_model.post(5'h15);
        chk({9'h000, host_irq, host_irq_is_event, host_event_field}, 16'h0075);
        u_hpa_mpu_model.xfer(1'b1, HPA_ADDR_DS, 16'h1111, q);
        chk({9'h000, host_irq, host_irq_is_event, 5'h00}, 16'h0040);
        iack();
        chk({9'h000, host_irq, host_irq_is_event, host_event_field}, 16'h0075);
        iack();
        chk({15'h0000, host_irq}, 16'h0000);
    endtask
    task automatic t_err();
        logic [15:0] q;
        hx(1'b1, HPA_ADDR_CS1, 16'h0057, q);
        u_hpa_mpu_model.clr(4'hF);
        hx(1'b1, HPA_ADDR_PAR_FIRST + 4'h1, 16'h0001, q);
        chk({12'h000, mpu_evt_flags}, 16'h0008);
        u_hpa_mpu_model.clr(4'hF);
        hx(1'b1, HPA_ADDR_CS1, 16'h0057, q);
        chk({12'h000, mpu_evt_flags}, 16'h0009);
        // Clear only the command flag; the error flag must stay
        u_hpa_mpu_model.clr(4'h1);
        chk({12'h000, mpu_evt_flags}, 16'h0008);
        hx(1'b0, HPA_ADDR_CS2, 16'h0000, q);
        chk(q, 16'h0401);
        hx(1'b1, HPA_ADDR_CS2, 16'h0021, q);
        chk({12'h000, mpu_evt_flags & 4'h2}, 16'h0002);
        hx(1'b1, HPA_ADDR_CS1, 16'h0057, q);
        u_hpa_mpu_model.clr(4'hF);
        @(negedge clk_sys);
        host_init = 1'b1;
        repeat (3) @(negedge clk_sys);
        host_init = 1'b0;
        chk({11'h000, host_irq, mpu_evt_flags & 4'h4}, 16'h0004);
        hx(1'b0, HPA_ADDR_CS1, 16'h0000, q);
        chk(q & 16'h0081, 16'h0080);
    endtask
    initial begin
        {sys_rst, host_req, host_we, host_init, host_irq_ack} = 5'h10;
        host_addr = 4'h0;
        host_wdata = 16'h0000;
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        t_cmd();
        t_units();
        t_event();
        t_err();
        summarize();
    end
    // Tests need well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        summarize();
    end
endmodule

// File: verilog/hpa_host_port_adapter.sv
/*
 Host port adapter: shared parameter file, go/ready handshake, reset and
 programming error detection, interrupts to both sides.
 Assumes both requesters hold their request until acknowledged.
*/
// Functional notes
// - Parameters and per-drive status kept in a file both sides access.
// - Unit selection steers each drive status access to that drive's entry.
// - Simultaneous requests are arbitrated; both always complete.
// - Both control status words mix flip-flops and file storage.
// - One go flag per drive allows overlapped seeks.
// - Go and ready update automatically from accesses and resets.
// - Programmed reset or bus initialize sets event and interrupts processor.
// - Host interrupts for command completion and event completion.
// - Command completion preempts event completion and sets ready.
// - Event completion carries a 5-bit firmware field read by host.
// - New parameter while command in progress flags programming error.
// - Drive storage and go flags sized for four drives.
// - Transfer start clears ready; setting go raises command event.
// - Processor drive status write clears go, sets ready, maybe interrupts.
// - Initialize edge resets interrupts, sets ready, clears go, set-ready event.
// - Transfer while not ready flags error but still takes function and go.
`timescale 1ns/1ps
module hpa_host_port_adapter
    import hpa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic host_req,
    input wire logic host_we,
    input wire logic [HPA_ADDR_W-1:0] host_addr,
    input wire logic [HPA_DATA_W-1:0] host_wdata,
    output logic host_ack,
    output logic [HPA_DATA_W-1:0] host_rdata,
    input wire logic host_init,
    output logic host_irq,
    input wire logic host_irq_ack,
    output logic host_irq_is_event,
    output logic [HPA_EVT_FIELD_W-1:0] host_event_field,
    input wire logic mpu_req,
    input wire logic mpu_we,
    input wire logic [HPA_ADDR_W-1:0] mpu_addr,
    input wire logic [HPA_DATA_W-1:0] mpu_wdata,
    output logic mpu_ack,
    output logic [HPA_DATA_W-1:0] mpu_rdata,
    input wire logic mpu_event_post,
    input wire logic [HPA_EVT_FIELD_W-1:0] mpu_event_field,
    input wire logic [HPA_EVT_W-1:0] mpu_evt_clear,
    output logic [HPA_EVT_W-1:0] mpu_evt_flags,
    output logic mpu_irq
);
    // ****************************************
    // State
    // ****************************************
    hpa_arb_t grant;
    logic last_host_reg, last_host_next;
    logic [HPA_NUM_DRIVES-1:0] go_reg, go_next;
    logic rdy_reg, rdy_next;
    logic ie_reg, ie_next;
    logic pge_reg, pge_next;
    logic [HPA_UNIT_W-1:0] unit_reg, unit_next;
    logic [HPA_CS1_FUNC_W-1:0] func_reg, func_next;
    logic [HPA_EVT_W-1:0] evt_reg, evt_next;
    logic cmd_irq_reg, cmd_irq_next;
    logic ev_irq_reg, ev_irq_next;
    logic [HPA_EVT_FIELD_W-1:0] ev_field_reg, ev_field_next;
    logic init_d_reg;
    logic [HPA_DATA_W-1:0] host_rdata_reg, host_rdata_next;
    logic [HPA_DATA_W-1:0] mpu_rdata_reg, mpu_rdata_next;
    logic [HPA_EVT_W-1:0] evt_set;

    logic rf_we;
    logic [HPA_ADDR_W-1:0] rf_addr;
    logic [HPA_DATA_W-1:0] rf_wdata, rf_rdata;
    logic acc_we;
    logic [HPA_ADDR_W-1:0] acc_addr;
    logic [HPA_DATA_W-1:0] acc_wdata, reg_view;
    logic init_rise;

    function automatic logic is_xfer(input logic [HPA_CS1_FUNC_W-1:0] f);
        return (f >= HPA_FUNC_XFER_MIN);
    endfunction

    // ****************************************
    // Arbitration
    // ****************************************
    // Priority on collisions goes to the side not granted last, so neither side can starve
    always_comb begin
        grant = HPA_ARB_IDLE;
        if (host_req && mpu_req) begin
            grant = last_host_reg ? HPA_ARB_MPU : HPA_ARB_HOST;
        end else if (host_req) begin
            grant = HPA_ARB_HOST;
        end else if (mpu_req) begin
            grant = HPA_ARB_MPU;
        end
        last_host_next = last_host_reg;
        if (grant == HPA_ARB_HOST) begin
            last_host_next = 1'b1;
        end else if (grant == HPA_ARB_MPU) begin
            last_host_next = 1'b0;
        end
    end

    // Handshake held low for the loser, which stalls it
    assign host_ack = (grant == HPA_ARB_HOST);
    assign mpu_ack = (grant == HPA_ARB_MPU);

    always_comb begin
        case (grant)
            HPA_ARB_HOST: begin
                acc_we = host_we;
                acc_addr = host_addr;
                acc_wdata = host_wdata;
            end
            HPA_ARB_MPU: begin
                acc_we = mpu_we;
                acc_addr = mpu_addr;
                acc_wdata = mpu_wdata;
            end
            default: begin
                acc_we = 1'b0;
                acc_addr = HPA_ADDR_CS1;
                acc_wdata = HPA_DATA_RST;
            end
        endcase
    end

    // ****************************************
    // Register file
    // ****************************************
    assign rf_we = acc_we;
    assign rf_addr = acc_addr;
    assign rf_wdata = acc_wdata;

    hpa_regfile u_regfile (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wr_en(rf_we),
        .addr(rf_addr),
        .unit(unit_reg),
        .wr_data(rf_wdata),
        .rd_data(rf_rdata)
    );

    // Status words overlay discrete flops on file bits
    always_comb begin
        reg_view = rf_rdata;
        if (acc_addr == HPA_ADDR_CS1) begin
            reg_view[HPA_CS1_GO_BIT] = go_reg[unit_reg];
            reg_view[HPA_CS1_FUNC_LSB +: HPA_CS1_FUNC_W] = func_reg;
            reg_view[HPA_CS1_IE_BIT] = ie_reg;
            reg_view[HPA_CS1_RDY_BIT] = rdy_reg;
        end else if (acc_addr == HPA_ADDR_CS2) begin
            reg_view[HPA_CS2_UNIT_LSB +: HPA_UNIT_W] = unit_reg;
            reg_view[HPA_CS2_PGE_BIT] = pge_reg;
        end
    end

    // ****************************************
    // Handshake and events
    // ****************************************
    assign init_rise = host_init && !init_d_reg;

    always_comb begin
        logic [HPA_CS1_FUNC_W-1:0] wfunc;
        wfunc = acc_wdata[HPA_CS1_FUNC_LSB +: HPA_CS1_FUNC_W];
        go_next = go_reg;
        rdy_next = rdy_reg;
        ie_next = ie_reg;
        pge_next = pge_reg;
        unit_next = unit_reg;
        func_next = func_reg;
        evt_set = '0;
        cmd_irq_next = cmd_irq_reg;
        ev_irq_next = ev_irq_reg;
        ev_field_next = ev_field_reg;
        host_rdata_next = host_rdata_reg;
        mpu_rdata_next = mpu_rdata_reg;
        if (grant == HPA_ARB_HOST) begin
            host_rdata_next = reg_view;
        end
        if (grant == HPA_ARB_MPU) begin
            mpu_rdata_next = reg_view;
        end
        if (grant == HPA_ARB_HOST && acc_we) begin
            if (acc_addr == HPA_ADDR_CS1) begin
                ie_next = acc_wdata[HPA_CS1_IE_BIT];
                func_next = wfunc;
                if (acc_wdata[HPA_CS1_GO_BIT]) begin
                    go_next[unit_reg] = 1'b1;
                    evt_set[HPA_EVT_GO] = 1'b1;
                    if (is_xfer(wfunc)) begin
                        rdy_next = 1'b0;
                        if (!rdy_reg) begin
                            pge_next = 1'b1;
                            evt_set[HPA_EVT_PER] = 1'b1;
                        end
                    end
                end
            end else if (acc_addr == HPA_ADDR_CS2) begin
                unit_next = acc_wdata[HPA_CS2_UNIT_LSB +: HPA_UNIT_W];
                if (acc_wdata[HPA_CS2_CLR_BIT]) begin
                    evt_set[HPA_EVT_RESET] = 1'b1;
                    pge_next = 1'b0;
                end
            end else if (acc_addr >= HPA_ADDR_PAR_FIRST && !rdy_reg) begin
                pge_next = 1'b1;
                evt_set[HPA_EVT_PER] = 1'b1;
            end
        end
        if (grant == HPA_ARB_MPU && acc_we) begin
            if (acc_addr == HPA_ADDR_DS) begin
                go_next[unit_reg] = 1'b0;
                rdy_next = 1'b1;
                if (ie_reg) begin
                    cmd_irq_next = 1'b1;
                end
            end
        end
        if (mpu_event_post && ie_reg) begin
            ev_irq_next = 1'b1;
            ev_field_next = mpu_event_field;
        end
        // Acknowledge clears the source currently shown
        if (host_irq_ack) begin
            if (cmd_irq_reg) begin
                cmd_irq_next = 1'b0;
            end else begin
                ev_irq_next = 1'b0;
            end
        end
        if (init_rise) begin
            go_next = '0;
            rdy_next = 1'b1;
            ie_next = 1'b0;
            cmd_irq_next = 1'b0;
            ev_irq_next = 1'b0;
            evt_set[HPA_EVT_SR] = 1'b1;
        end
        // Hardware set wins over firmware clear
        evt_next = (evt_reg & ~mpu_evt_clear) | evt_set;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            last_host_reg <= 1'b0;
            go_reg <= '0;
            rdy_reg <= 1'b1;
            ie_reg <= 1'b0;
            pge_reg <= 1'b0;
            unit_reg <= '0;
            func_reg <= '0;
            evt_reg <= '0;
            cmd_irq_reg <= 1'b0;
            ev_irq_reg <= 1'b0;
            ev_field_reg <= '0;
            init_d_reg <= 1'b0;
            host_rdata_reg <= HPA_DATA_RST;
            mpu_rdata_reg <= HPA_DATA_RST;
        end else begin
            last_host_reg <= last_host_next;
            go_reg <= go_next;
            rdy_reg <= rdy_next;
            ie_reg <= ie_next;
            pge_reg <= pge_next;
            unit_reg <= unit_next;
            func_reg <= func_next;
            evt_reg <= evt_next;
            cmd_irq_reg <= cmd_irq_next;
            ev_irq_reg <= ev_irq_next;
            ev_field_reg <= ev_field_next;
            init_d_reg <= host_init;
            host_rdata_reg <= host_rdata_next;
            mpu_rdata_reg <= mpu_rdata_next;
        end
    end

    assign host_rdata = host_rdata_reg;
    assign mpu_rdata = mpu_rdata_reg;
    assign mpu_evt_flags = evt_reg;
    assign mpu_irq = |evt_reg;
    assign host_irq = cmd_irq_reg | ev_irq_reg;
    assign host_irq_is_event = !cmd_irq_reg && ev_irq_reg;
    assign host_event_field = ev_field_reg;
endmodule

// File: verilog/hpa_pkg.sv
/*
 Package for the host port adapter: register file layout, event flag
 positions, handshake states and reset values.
 Assumes a single 200 MHz clock and plain-port access from both sides.
*/
package hpa_pkg;
    localparam int HPA_NUM_DRIVES = 4;
    localparam int HPA_UNIT_W = 2;
    localparam int HPA_DATA_W = 16;
    localparam int HPA_ADDR_W = 4;
    localparam int HPA_EVT_FIELD_W = 5;
    // Shared register file addresses; drive status is per unit
    localparam logic [3:0] HPA_ADDR_CS1 = 4'h0;
    localparam logic [3:0] HPA_ADDR_CS2 = 4'h1;
    localparam logic [3:0] HPA_ADDR_DS = 4'h2;
    localparam logic [3:0] HPA_ADDR_PAR_FIRST = 4'h3;
    // Control status one field positions
    localparam int HPA_CS1_GO_BIT = 0;
    localparam int HPA_CS1_FUNC_LSB = 1;
    localparam int HPA_CS1_FUNC_W = 5;
    localparam int HPA_CS1_IE_BIT = 6;
    localparam int HPA_CS1_RDY_BIT = 7;
    // Control status two field positions
    localparam int HPA_CS2_UNIT_LSB = 0;
    localparam int HPA_CS2_CLR_BIT = 5;
    localparam int HPA_CS2_PGE_BIT = 10;
    // Function code that starts a data transfer (every code at or above it)
    localparam logic [4:0] HPA_FUNC_XFER_MIN = 5'h0A;
    // Event flag positions toward the microprocessor
    localparam int HPA_EVT_GO = 0;
    localparam int HPA_EVT_RESET = 1;
    localparam int HPA_EVT_SR = 2;
    localparam int HPA_EVT_PER = 3;
    localparam int HPA_EVT_W = 4;
    localparam logic [15:0] HPA_DATA_RST = 16'h0000;
    // Requester select
    typedef enum logic [2:0] {
        HPA_ARB_IDLE = 3'b001,
        HPA_ARB_HOST = 3'b010,
        HPA_ARB_MPU = 3'b100
    } hpa_arb_t;
endpackage

// File: verilog/hpa_regfile.sv
/*
 Flip-flop register file of the host port adapter: common words plus one
 drive status word per unit, addressed by index.
 Assumes the caller arbitrates so only one write arrives per cycle.
*/
`timescale 1ns/1ps
module hpa_regfile
    import hpa_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [HPA_ADDR_W-1:0] addr,
    input wire logic [HPA_UNIT_W-1:0] unit,
    input wire logic [HPA_DATA_W-1:0] wr_data,
    output logic [HPA_DATA_W-1:0] rd_data
);
    localparam int DEPTH = 16 + HPA_NUM_DRIVES;
    logic [HPA_DATA_W-1:0] mem_reg [DEPTH];
    logic [HPA_DATA_W-1:0] mem_next [DEPTH];

    // ****************************************
    // Index decode
    // ****************************************
    function automatic int map_index(input logic [HPA_ADDR_W-1:0] a,
                                     input logic [HPA_UNIT_W-1:0] u);
        if (a == HPA_ADDR_DS) begin
            return 16 + int'(u);
        end
        return int'(a);
    endfunction

    always_comb begin
        int idx;
        idx = map_index(addr, unit);
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (wr_en) begin
            mem_next[idx] = wr_data;
        end
        rd_data = mem_reg[idx];
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= sys_rst ? HPA_DATA_RST : mem_next[i];
        end
    end
endmodule
